// [logic/hts_pkg.sv]
// Behaviour
// - Take one field sample every 16.67 us; this tick drives all decisions.
// - Decision value is the mean of newest and previous field samples.
// - Average above operate threshold pulls the open-drain output low.
// - Average below release threshold releases the output to high impedance.
// - Between thresholds the previous output state is held (hysteresis).
// - Field is signed, south positive; weak, zero or north fields release.
// - Output changes only at a tick whose average has crossed a threshold.
// - Field crossing to output change is 13 us typical, at most 25 us.
// - Output is invalid until power-on time, 40 us typical, 70 us max.
// - Power-up between thresholds leaves output undefined until a crossing.
// - Operate threshold is a per-variant parameter: 2.9, 9.2 or 17.9 mT.
// - Release threshold per variant: 1.8, 7.0 or 14.1 mT, below operate.
// - Output only sinks to ground or floats, never drives high.
package hts_pkg;
    localparam int FIELD_W = 16;
    // Field codes are in microtesla.
    localparam int OPERATE_A1_UT = 2900;
    localparam int RELEASE_A1_UT = 1800;
    localparam int OPERATE_A2_UT = 9200;
    localparam int RELEASE_A2_UT = 7000;
    localparam int OPERATE_A3_UT = 17900;
    localparam int RELEASE_A3_UT = 14100;
    localparam int CLK_PERIOD_PS = 10000;
    localparam int SAMPLE_PERIOD_PS = 16670000;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_PS / CLK_PERIOD_PS;
    localparam int POWER_ON_TYP_US = 40;
    localparam int POWER_ON_CYCLES =
        (POWER_ON_TYP_US * 1000000) / CLK_PERIOD_PS;
    localparam int PROP_MAX_US = 25;
    localparam int PROP_MAX_CYCLES = (PROP_MAX_US * 1000000) / CLK_PERIOD_PS;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] CNT_RESET = 12'h0000;
endpackage

// [logic/hts_sample_hold.sv]
`timescale 1ns/10ps
`default_nettype none
module hts_sample_hold
    import hts_pkg::*;
#(
    parameter int W = FIELD_W
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst,
    input  wire logic         i_tick,
    input  wire logic [W-1:0] i_field,
    output var  logic [W-1:0] o_newest,
    output var  logic [W-1:0] o_previous,
    output var  logic         o_primed
);
    // Two-entry sample history; primed once both entries are real samples.
    logic [1:0] fill;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_newest   <= '0;
            o_previous <= '0;
        end else if (i_tick) begin
            o_previous <= o_newest;
            o_newest   <= i_field;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            fill <= 2'h0;
        end else if (i_tick && fill != 2'h2) begin
            fill <= fill + 2'h1;
        end
    end

    assign o_primed = (fill == 2'h2);
endmodule // hts_sample_hold
`default_nettype wire

// [logic/hts_switch.sv]
`timescale 1ns/10ps
`default_nettype none
module hts_switch
    import hts_pkg::*;
#(
    parameter int W = FIELD_W,
    parameter int OPERATE_UT = OPERATE_A1_UT,
    parameter int RELEASE_UT = RELEASE_A1_UT,
    parameter int SAMPLE_CNT = SAMPLE_CYCLES,
    parameter int POWER_CNT = POWER_ON_CYCLES
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_field,
    input  wire logic         i_out_pin,
    output logic              o_out_pin,
    output logic              o_out_pin_oe,
    output logic              o_valid,
    output logic              o_sample_tick
);
    typedef enum logic [2:0] {
        ST_POWERUP = 3'b001,
        ST_RELEASE = 3'b010,
        ST_OPERATE = 3'b100
    } hts_state_e;

    localparam logic signed [W:0] OP_TWICE = (W+1)'(2 * OPERATE_UT);
    localparam logic signed [W:0] RP_TWICE = (W+1)'(2 * RELEASE_UT);

    hts_state_e       state;
    hts_state_e       next_state;
    logic [CNT_W-1:0] tick_cnt;
    logic [CNT_W-1:0] pwr_cnt;
    logic             pwr_done;
    logic             tick;
    logic [W-1:0]     field_meta;
    logic [W-1:0]     field_sync;
    logic             pin_meta;
    logic             pin_sync;
    logic [W-1:0]     newest;
    logic [W-1:0]     previous;
    logic             primed;
    logic signed [W:0] sum2;
    logic             above_op;
    logic             below_rp;
    logic             decide;
    logic             crossed;
    logic [CNT_W-1:0] lag_cnt;

    // Field code comes from the analog front end, so it is resynchronised.
    // Multi-bit codes are assumed to change slowly relative to the clock.
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            field_meta <= '0;
            field_sync <= '0;
            pin_meta   <= 1'b1;
            pin_sync   <= 1'b1;
        end else begin
            field_meta <= i_field;
            field_sync <= field_meta;
            pin_meta   <= i_out_pin;
            pin_sync   <= pin_meta;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_cnt <= CNT_RESET;
            tick     <= 1'b0;
        end else if (tick_cnt == CNT_W'(SAMPLE_CNT - 1)) begin
            tick_cnt <= CNT_RESET;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick     <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pwr_cnt  <= CNT_RESET;
            pwr_done <= 1'b0;
        end else if (pwr_cnt == CNT_W'(POWER_CNT - 1)) begin
            pwr_done <= 1'b1;
        end else begin
            pwr_cnt <= pwr_cnt + 1'b1;
        end
    end

    hts_sample_hold #(
        .W (W)
    ) u_hold (
        .i_sys_clk  (i_sys_clk),
        .i_rst      (i_rst),
        .i_tick     (tick),
        .i_field    (field_sync),
        .o_newest   (newest),
        .o_previous (previous),
        .o_primed   (primed)
    );

    // Comparing the sum against twice each threshold keeps the mean exact.
    assign sum2 = $signed({newest[W-1], newest})
                + $signed({previous[W-1], previous});
    assign above_op = sum2 > OP_TWICE;
    assign below_rp = sum2 < RP_TWICE;

    always_comb begin
        next_state = state;
        case (state)
            ST_POWERUP: begin
                if (above_op) next_state = ST_OPERATE;
                else if (below_rp) next_state = ST_RELEASE;
            end
            ST_RELEASE: if (above_op) next_state = ST_OPERATE;
            ST_OPERATE: if (below_rp) next_state = ST_RELEASE;
            default: next_state = ST_POWERUP;
        endcase
    end

    // The tick itself loads the history, so the decision waits one cycle.
    // Deciding on the tick would average the two samples before the newest
    // one and add a whole sample period to the propagation delay.
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            decide <= 1'b0;
        end else begin
            decide <= tick;
        end
    end

    // Decisions are taken only in the cycle after a tick, with two real samples held and power-on done.
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_POWERUP;
        end else if (decide && primed && pwr_done) begin
            state <= next_state;
        end
    end

    // Cycles in which a crossed average still waits for its decision.
    assign crossed = (state != ST_OPERATE && above_op)
                  || (state != ST_RELEASE && below_rp);

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            lag_cnt <= CNT_RESET;
        end else if (primed && pwr_done && crossed) begin
            lag_cnt <= lag_cnt + 1'b1;
        end else begin
            lag_cnt <= CNT_RESET;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_out_pin     <= 1'b0;
            o_out_pin_oe  <= 1'b0;
            o_valid       <= 1'b0;
            o_sample_tick <= 1'b0;
        end else begin
            o_out_pin     <= 1'b0;
            o_out_pin_oe  <= (state == ST_OPERATE);
            o_valid       <= pwr_done && (state != ST_POWERUP);
            o_sample_tick <= tick;
        end
    end

    // Timing of the sample strobe.
    chk_tick_spacing: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        tick |=> !tick [*8]) else $error("sample tick too close");
    chk_tick_bound: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        tick_cnt < CNT_W'(SAMPLE_CNT)) else $error("tick count overrun");

    // Output stage.
    chk_never_high: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_out_pin == 1'b0) else $error("output driven high");
    chk_operate_low: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == ST_OPERATE) |=> o_out_pin_oe) else $error("no pull low");
    chk_release_float: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (state != ST_OPERATE) |=> !o_out_pin_oe) else $error("stuck low");
    // The released readback only holds while a pullup sits on the far side of the pin.
    chk_pin_pulled_low: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_out_pin_oe [*3] |-> !pin_sync) else $error("pin not low");
    chk_pin_released: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        !o_out_pin_oe [*3] |-> pin_sync) else $error("pin not high");

    // Decision timing and hysteresis.
    chk_hold_between: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (!above_op && !below_rp) |=> $stable(state)) else $error("hyst");
    chk_only_on_tick: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        !decide |=> $stable(state)) else $error("change off tick");
    chk_op_reacts: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (decide && primed && pwr_done && above_op) |=> ##1 o_out_pin_oe)
        else $error("late operate");
    chk_release_reacts: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (decide && primed && pwr_done && below_rp) |=> ##1 !o_out_pin_oe)
        else $error("late release");
    chk_prop_bound: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        lag_cnt <= CNT_W'(SAMPLE_CNT)) else $error("decision too late");
    chk_north_float: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (decide && primed && pwr_done && sum2 < 0) |=> ##1 !o_out_pin_oe)
        else $error("north not released");

    // Power-on and the undefined start.
    chk_power_gate: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        !pwr_done |=> !o_valid && !o_out_pin_oe) else $error("early out");
    chk_early_state: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        !pwr_done |-> state == ST_POWERUP) else $error("early decision");
    chk_unprimed_wait: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        !primed |-> state == ST_POWERUP) else $error("decision unprimed");
    chk_undef_flag: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (state == ST_POWERUP) |=> !o_valid) else $error("valid early");
    chk_valid_follows: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (decide && primed && pwr_done && (above_op || below_rp))
        |=> ##1 o_valid) else $error("valid late");
    chk_valid_kept: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_valid |=> o_valid) else $error("valid lost");
endmodule // hts_switch
`default_nettype wire

// [tb/hts_pullup_pin.sv]
`timescale 1ns/10ps
`default_nettype none
module hts_pullup_pin (
    input  wire logic i_oe,
    input  wire logic i_drive,
    output var  logic o_pin
);
    // The pullup sets the released level, so the device never drives high.
    assign o_pin = i_oe ? i_drive : 1'b1;
endmodule // hts_pullup_pin
`default_nettype wire

// [tb/sampled_hall_threshold_switch_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module sampled_hall_threshold_switch_bench;
    import hts_pkg::*;
    localparam int SC = 20;
    localparam int PC = 50;
    logic               i_sys_clk = 1'b0;
    logic               i_rst = 1'b1;
    logic [FIELD_W-1:0] field = '0;
    logic               pin;
    logic               drive;
    logic               oe;
    logic               valid;
    logic               sample_tick;
    logic               state = 1'b0;
    int                 failures = 0;
    int                 checked = 0;
    int                 cycles = 0;
    int                 seed = 31;
    int                 gap = 0;
    hts_switch #(.SAMPLE_CNT(SC), .POWER_CNT(PC)) hts_switch_inst (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_field(field),
        .i_out_pin(pin), .o_out_pin(drive), .o_out_pin_oe(oe),
        .o_valid(valid), .o_sample_tick(sample_tick));
    hts_pullup_pin hts_pullup_pin_inst (
        .i_oe(oe), .i_drive(drive), .o_pin(pin));
    initial forever #5 i_sys_clk = ~i_sys_clk;
    task automatic test_done();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures++;
            test_done();
        end
    end
    function automatic logic expect_oe(int f, logic prev);
        if (f > OPERATE_A1_UT) return 1'b1;
        if (f < RELEASE_A1_UT) return 1'b0;
        return prev;
    endfunction
    task automatic check(logic got, logic exp, string msg);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    // Tick pulses must come exactly SC cycles apart outside reset.
    always @(negedge i_sys_clk) begin
        if (i_rst) begin
            gap = 0;
        end else if (sample_tick === 1'b1) begin
            if (gap > 0) check(gap == SC, 1'b1, "tick spacing");
            gap = 1;
        end else if (gap > 0) begin
            gap = gap + 1;
        end
    end
    task automatic restart();
        @(negedge i_sys_clk) i_rst = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        i_rst = 1'b0;
    endtask
    // A change must land within two ticks; then it must stay put.
    task automatic settle(int f);
        @(negedge i_sys_clk) field = f[FIELD_W-1:0];
        state = expect_oe(f, state);
        for (int n = 0; n < 2 * SC + 6 && oe !== state; n++)
            @(negedge i_sys_clk);
        check(oe, state, "output enable");
        check(pin, ~state, "pin level");
        repeat (2 * SC) @(negedge i_sys_clk);
        check(oe, state, "output held");
    endtask
    initial begin
        field = 16'h1388;
        restart();
        repeat (PC - 10) @(negedge i_sys_clk);
        check(oe, 1'b0, "early output");
        check(valid, 1'b0, "early valid");
        settle(5000);
        check(valid, 1'b1, "valid after decision");
        settle(2500);
        settle(1799);
        settle(2900);
        settle(2901);
        settle(1800);
        settle(-20000);
        settle(0);
        // Exactly one tick sees the spike, so the average stays between.
        @(negedge i_sys_clk) field = 16'h0FA0;
        repeat (SC) @(negedge i_sys_clk);
        field = '0;
        repeat (3 * SC) @(negedge i_sys_clk);
        check(oe, 1'b0, "single sample spike");
        repeat (20) settle($random(seed) % 25000);
        @(negedge i_sys_clk) field = 16'h09C4;
        restart();
        repeat (PC + 3 * SC) @(negedge i_sys_clk);
        check(valid, 1'b0, "undefined start");
        check(oe, 1'b0, "released while undefined");
        state = 1'b0;
        settle(6000);
        check(valid, 1'b1, "valid after crossing");
        test_done();
    end
endmodule // sampled_hall_threshold_switch_bench
`default_nettype wire
